/* sidb_regs.vh */
/*
  sidb_regs.vh: offsets, field positions and reset values for the system
  identification and band-gap register bank.
  assumes: included by bare name; byte addresses on a 32-bit avalon bus.
*/
`ifndef SIDB_REGS_VH
`define SIDB_REGS_VH

`define SIDB_ADDR_W            14
`define SIDB_UID1_OFS          14'h1840
`define SIDB_UID2_OFS          14'h1844
`define SIDB_UID3_OFS          14'h1848
`define SIDB_UID4_OFS          14'h184c
`define SIDB_UID5_OFS          14'h1850
`define SIDB_BGC_OFS           14'h2300
`define SIDB_BGC_CLR_OFS       14'h2304
`define SIDB_BGC_SET_OFS       14'h2308
`define SIDB_BGC_INV_OFS       14'h230c
`define SIDB_PART_ID_OFS       14'h3b20
`define SIDB_KEY_OFS           14'h3b30

`define SIDB_REV_HI            31
`define SIDB_REV_LO            28
`define SIDB_PNUM_HI           27
`define SIDB_PNUM_LO           0
`define SIDB_BGC_CONV_BIT      2
`define SIDB_BGC_CMP_BIT       1
`define SIDB_BGC_MASK          32'h00000006
`define SIDB_BGC_RST           32'h00000000
`define SIDB_KEY_RST           32'h00000000
`define SIDB_READ_LAT          1

`endif

/* sidb_bgc_bit.v */
/*
  sidb_bgc_bit.v: one band-gap enable bit with write, clear, set and
  toggle aliases plus hardware set and clear inputs.
  assumes: strobes are one-cycle pulses synchronous to sys_clk.
*/
`default_nettype none

module sidb_bgc_bit (
  // clock and reset
  input  wire sys_clk,
  input  wire rstn,
  // software access
  input  wire sw_wr,
  input  wire sw_clr,
  input  wire sw_set,
  input  wire sw_inv,
  input  wire sw_dat,
  // hardware events
  input  wire hw_set,
  input  wire hw_clr,
  // stored bit
  output reg  bit_reg
);

  reg bit_next;

  always @* begin
    bit_next = bit_reg;
    if (sw_wr)
      bit_next = sw_dat;
    if (sw_clr && sw_dat)
      bit_next = 1'b0;
    if (sw_set && sw_dat)
      bit_next = 1'b1;
    if (sw_inv && sw_dat)
      bit_next = ~bit_reg;
    if (hw_clr)
      bit_next = 1'b0;
    if (hw_set)
      bit_next = 1'b1;
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      bit_reg <= 1'b0;
    else
      bit_reg <= bit_next;
  end

endmodule // sidb_bgc_bit

`default_nettype wire

/* sidb_top.v */
/*
  sidb_top.v: system id, unlock key, band-gap control and unique id bank
  behind an avalon-mm slave with waitrequest.
  assumes: one clock sys_clk, async active-low rstn; id and unique id
  values come from tie-off inputs that are stable.
  // Operation
  // - id word: revision in 31:28, part number in 27:0, read-only.
  // - id value comes from variant tie-offs, not one constant.
  // - 32-bit write-only key register, resets to zero.
  // - band-gap bit 2 enables converter reference, resets to 0.
  // - band-gap bit 1 enables comparator reference, resets to 0.
  // - enable bits writable by software and set/cleared by hardware.
  // - aliases at +4, +8, +c clear, set, invert the written ones.
  // - band-gap bits 31:3 and 0 read zero, ignore writes.
*/
`include "sidb_regs.vh"
`default_nettype none

module sidb_top (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rstn,
  // avalon-mm slave
  input  wire [13:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output reg  [1:0]  avs_response,
  // variant tie-offs
  input  wire [3:0]  silicon_revision,
  input  wire [27:0] part_number_field,
  input  wire [31:0] unique_id_word1,
  input  wire [31:0] unique_id_word2,
  input  wire [31:0] unique_id_word3,
  input  wire [31:0] unique_id_word4,
  input  wire [31:0] unique_id_word5,
  // hardware events on band-gap enables
  input  wire        conv_ref_hw_set,
  input  wire        conv_ref_hw_clr,
  input  wire        cmp_ref_hw_set,
  input  wire        cmp_ref_hw_clr,
  // outputs
  output wire        converter_ref_enable,
  output wire        comparator_ref_enable,
  output wire [31:0] system_unlock_key,
  output reg         key_write_pulse
);

  localparam ST_IDLE = 1'b0;
  localparam ST_DONE = 1'b1;

  reg         state_reg;
  reg         state_next;
  reg  [31:0] key_reg;
  reg  [31:0] rdata_next;
  reg         hit_next;
  wire        req;
  wire        take;
  wire [31:0] wmask;
  wire [31:0] wdat;
  wire        bgc_wr;
  wire        bgc_clr;
  wire        bgc_set;
  wire        bgc_inv;
  wire [31:0] bgc_val;

  assign req  = avs_read | avs_write;
  // one wait cycle: accepted on the edge after the request is seen
  assign avs_waitrequest = req & (state_reg == ST_IDLE);
  assign take = req & (state_reg == ST_DONE);

  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdat  = avs_writedata & wmask;

  assign bgc_wr  = take & avs_write & (avs_address == `SIDB_BGC_OFS);
  assign bgc_clr = take & avs_write & (avs_address == `SIDB_BGC_CLR_OFS);
  assign bgc_set = take & avs_write & (avs_address == `SIDB_BGC_SET_OFS);
  assign bgc_inv = take & avs_write & (avs_address == `SIDB_BGC_INV_OFS);

  always @* begin
    case (state_reg)
      ST_IDLE: state_next = req ? ST_DONE : ST_IDLE;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  sidb_bgc_bit u_conv_bit (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .sw_wr   (bgc_wr & avs_byteenable[0]),
    .sw_clr  (bgc_clr),
    .sw_set  (bgc_set),
    .sw_inv  (bgc_inv),
    .sw_dat  (wdat[`SIDB_BGC_CONV_BIT]),
    .hw_set  (conv_ref_hw_set),
    .hw_clr  (conv_ref_hw_clr),
    .bit_reg (converter_ref_enable)
  );

  sidb_bgc_bit u_cmp_bit (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .sw_wr   (bgc_wr & avs_byteenable[0]),
    .sw_clr  (bgc_clr),
    .sw_set  (bgc_set),
    .sw_inv  (bgc_inv),
    .sw_dat  (wdat[`SIDB_BGC_CMP_BIT]),
    .hw_set  (cmp_ref_hw_set),
    .hw_clr  (cmp_ref_hw_clr),
    .bit_reg (comparator_ref_enable)
  );

  assign bgc_val = {29'h0000000, converter_ref_enable,
                    comparator_ref_enable, 1'b0} & `SIDB_BGC_MASK;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      key_reg         <= `SIDB_KEY_RST;
      key_write_pulse <= 1'b0;
    end else begin
      key_write_pulse <= 1'b0;
      if (take && avs_write && avs_address == `SIDB_KEY_OFS) begin
        key_reg         <= (key_reg & ~wmask) | wdat;
        key_write_pulse <= 1'b1;
      end
    end
  end
  assign system_unlock_key = key_reg;

  always @* begin
    rdata_next = 32'h00000000;
    hit_next   = 1'b1;
    case (avs_address)
      `SIDB_PART_ID_OFS: rdata_next = {silicon_revision, part_number_field};
      `SIDB_KEY_OFS:     rdata_next = 32'h00000000;
      `SIDB_BGC_OFS,
      `SIDB_BGC_CLR_OFS,
      `SIDB_BGC_SET_OFS,
      `SIDB_BGC_INV_OFS: rdata_next = bgc_val;
      `SIDB_UID1_OFS:    rdata_next = unique_id_word1;
      `SIDB_UID2_OFS:    rdata_next = unique_id_word2;
      `SIDB_UID3_OFS:    rdata_next = unique_id_word3;
      `SIDB_UID4_OFS:    rdata_next = unique_id_word4;
      `SIDB_UID5_OFS:    rdata_next = unique_id_word5;
      default:           hit_next   = 1'b0;
    endcase
  end

  // read data registered while waitrequest is high, stands at the take edge
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
    end else if (req && state_reg == ST_IDLE) begin
      avs_readdata <= avs_read ? rdata_next : 32'h00000000;
      avs_response <= hit_next ? 2'h0 : 2'h3;
    end
  end

endmodule // sidb_top

`default_nettype wire

/* sidb_chk.sv */
/* sidb_chk.sv: port assertions for sidb_top.
   assumes: bound to sidb_top; one clock, async active-low reset. */
`include "sidb_regs.vh"
`default_nettype none
module sidb_chk (
  // clock and bus
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [13:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // tie-offs, events, outputs
  input wire logic [3:0]  silicon_revision,
  input wire logic [27:0] part_number_field,
  input wire logic [31:0] unique_id_word1,
  input wire logic        conv_ref_hw_set,
  input wire logic        cmp_ref_hw_set,
  input wire logic        cmp_ref_hw_clr,
  input wire logic        converter_ref_enable,
  input wire logic        comparator_ref_enable,
  input wire logic [31:0] system_unlock_key,
  input wire logic        key_write_pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence rd(a);
    avs_read && avs_waitrequest && avs_address == a;
  endsequence
  sequence key_wr;
    avs_write && avs_waitrequest && avs_address == `SIDB_KEY_OFS
      && avs_byteenable == 4'hf;
  endsequence
  id_read_a: assert property (rd(`SIDB_PART_ID_OFS) |=>
    avs_readdata == {silicon_revision, part_number_field})
    else $error("id read wrong");
  key_read_a: assert property (rd(`SIDB_KEY_OFS) |=>
    avs_readdata == 32'h0) else $error("key read not zero");
  bgc_read_a: assert property (rd(`SIDB_BGC_OFS) |=>
    avs_readdata == {29'h0, $past(converter_ref_enable),
    $past(comparator_ref_enable), 1'b0}) else $error("bgc read wrong");
  uid_read_a: assert property (rd(`SIDB_UID1_OFS) |=>
    avs_readdata == unique_id_word1) else $error("uid read wrong");
  rst_zero_a: assert property ($rose(rstn) |->
    !converter_ref_enable && !comparator_ref_enable
    && system_unlock_key == 32'h0) else $error("reset value wrong");
  key_write_a: assert property (key_wr |=> ##1 key_write_pulse
    && system_unlock_key == $past(avs_writedata, 2))
    else $error("key write wrong");
  hw_set_a: assert property (conv_ref_hw_set |=>
    converter_ref_enable) else $error("hw set lost");
  hw_clr_a: assert property (cmp_ref_hw_clr && !cmp_ref_hw_set |=>
    !comparator_ref_enable) else $error("hw clear lost");
endmodule // sidb_chk
bind sidb_top sidb_chk sidb_chk_i (.sys_clk, .rstn, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .silicon_revision, .part_number_field,
  .unique_id_word1, .conv_ref_hw_set, .cmp_ref_hw_set, .cmp_ref_hw_clr,
  .converter_ref_enable, .comparator_ref_enable, .system_unlock_key,
  .key_write_pulse);
`default_nettype wire

/* sidb_test.sv */
/* sidb_test.sv: self-checking bench for sidb_top.
   assumes: sidb_chk.sv compiled first; 200 MHz clock. */
`include "sidb_regs.vh"
`default_nettype none
module sidb_test;
  timeunit 1ns;
  timeprecision 1ps;
  // revision, part number and unique id values are arbitrary
  localparam logic [3:0] REV = 4'h5;
  localparam logic [27:0] PNUM = 28'h0a1b2c3;
  localparam logic [31:0] UID [5] = '{32'h1a2b3c4d, 32'h22334455,
    32'h5a5aa5a5, 32'h0f0e0d0c, 32'h76543210};
  typedef struct {logic [13:0] wa; logic [31:0] wd; logic [3:0] be;
    logic [13:0] ra; logic [31:0] q;} sidb_row_t;
  sidb_row_t rows [13] = '{
    '{14'h0, 0, 4'hf, `SIDB_BGC_OFS, 0},
    '{`SIDB_PART_ID_OFS, '1, 4'hf, `SIDB_PART_ID_OFS, {REV, PNUM}},
    '{`SIDB_KEY_OFS, 32'hc3a51e77, 4'hf, `SIDB_KEY_OFS, 0},
    '{`SIDB_BGC_OFS, '1, 4'hf, `SIDB_BGC_OFS, 6},
    '{`SIDB_BGC_CLR_OFS, 4, 4'hf, `SIDB_BGC_OFS, 2},
    '{`SIDB_BGC_INV_OFS, 6, 4'hf, `SIDB_BGC_OFS, 4},
    '{`SIDB_BGC_SET_OFS, 2, 4'hf, `SIDB_BGC_OFS, 6},
    '{`SIDB_BGC_OFS, 0, 4'he, `SIDB_BGC_OFS, 6},
    '{`SIDB_UID1_OFS, '1, 4'hf, `SIDB_UID1_OFS, UID[0]},
    '{14'h0, 0, 4'hf, `SIDB_UID2_OFS, UID[1]},
    '{14'h0, 0, 4'hf, `SIDB_UID3_OFS, UID[2]},
    '{14'h0, 0, 4'hf, `SIDB_UID4_OFS, UID[3]},
    '{14'h0, 0, 4'hf, `SIDB_UID5_OFS, UID[4]}};
  logic sys_clk = 0, rstn = 0, avs_read = 0, avs_write = 0;
  logic [13:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, system_unlock_key, q;
  logic [3:0] avs_byteenable = 0, silicon_revision = REV;
  logic [27:0] part_number_field = PNUM;
  logic [31:0] uid [5] = UID;
  logic [1:0] avs_response;
  logic conv_ref_hw_set = 0, conv_ref_hw_clr = 0, cmp_ref_hw_set = 0;
  logic cmp_ref_hw_clr = 0, avs_waitrequest, key_write_pulse;
  logic converter_ref_enable, comparator_ref_enable;
  int n_errors = 0, checks_done = 0;
  sidb_top sidb_top_i (.sys_clk, .rstn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .avs_response, .silicon_revision,
    .part_number_field, .unique_id_word1(uid[0]),
    .unique_id_word2(uid[1]), .unique_id_word3(uid[2]),
    .unique_id_word4(uid[3]), .unique_id_word5(uid[4]),
    .conv_ref_hw_set, .conv_ref_hw_clr, .cmp_ref_hw_set, .cmp_ref_hw_clr,
    .converter_ref_enable, .comparator_ref_enable, .system_unlock_key,
    .key_write_pulse);
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic acc(input logic w, input logic [13:0] a,
      input logic [31:0] d, input logic [3:0] be, output logic [31:0] rq);
    @(posedge sys_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    // hold until waitrequest is seen low at an edge
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      acc(1'b1, rows[i].wa, rows[i].wd, rows[i].be, q);
      acc(1'b0, rows[i].ra, 0, 4'hf, q);
      chk(q, rows[i].q);
      chk({30'h0, avs_response}, 0);
    end
    chk(system_unlock_key, 32'hc3a51e77);
    acc(1'b1, `SIDB_BGC_CLR_OFS, 32'h4, 4'hf, q);
    @(posedge sys_clk);
    conv_ref_hw_set <= 1'b1;
    conv_ref_hw_clr <= 1'b1;
    cmp_ref_hw_clr <= 1'b1;
    @(posedge sys_clk);
    conv_ref_hw_set <= 1'b0;
    conv_ref_hw_clr <= 1'b0;
    cmp_ref_hw_clr <= 1'b0;
    acc(1'b0, `SIDB_BGC_OFS, 0, 4'hf, q);
    chk(q, 32'h4);
    acc(1'b0, 14'h0400, 0, 4'hf, q);
    chk({30'h0, avs_response}, 32'h3);
    silicon_revision <= 4'h9;
    part_number_field <= 28'h7654321;
    acc(1'b0, `SIDB_PART_ID_OFS, 0, 4'hf, q);
    chk(q, 32'h97654321);
    @(posedge sys_clk);
    rstn <= 1'b0;
    @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    q = {30'h0, converter_ref_enable, comparator_ref_enable};
    chk(system_unlock_key | q, 0);
    end_of_test;
  end
endmodule // sidb_test
`default_nettype wire
